// ### hdl/mst_status_core.sv
// Machine status register, hart identifier and trap privilege stack
`timescale 1ns/1ps
module mst_status_core
    import mst_pkg::*;
#(
    parameter logic [31:0] HART_ID = 32'h0000_0000,
    parameter bit HAS_USER = 1'b1,
    parameter bit HAS_SUPER = 1'b1,
    parameter bit HAS_HYPER = 1'b0,
    parameter bit HAS_USER_IRQ = 1'b0,
    parameter bit HAS_FLOAT = 1'b0,
    parameter logic [31:0] SCHEME_IMPL_MASK = 32'h0000_0107
)
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Register access port
    input wire mst_csr_req_t i_csr_req,
    output logic [31:0] o_csr_rdata,
    output logic o_csr_rvalid,
    // Trap entry and return
    input wire mst_trap_req_t i_trap_req,
    // Extension context status from the extension units
    input wire logic [1:0] i_ext_status,
    // Interrupt gating
    input wire logic [3:0] i_irq_pending,
    output logic [3:0] o_irq_take,
    // Live state for the pipeline
    output logic [1:0] o_cur_priv,
    output logic [4:0] o_translation_scheme,
    output logic o_modify_privilege,
    output logic o_make_executable_readable,
    output logic o_protect_user_memory
);

    typedef struct packed
    {
        logic [1:0] priv;
        logic [3:0] irq_enable;
        logic [3:0] prior_irq_enable;
        logic [1:0] machine_prior_privilege;
        logic [1:0] hypervisor_prior_privilege;
        logic supervisor_prior_privilege;
        logic [4:0] translation_scheme;
        logic [1:0] float_context_status;
        logic make_executable_readable;
        logic protect_user_memory;
        logic modify_privilege;
        logic [31:0] rdata;
        logic rvalid;
    } mst_state_t;

    // Which enables exist; machine is always present
    localparam logic [3:0] IE_IMPL = {1'b1, HAS_HYPER, HAS_SUPER, HAS_USER_IRQ};
    localparam logic [1:0] LOWEST_PRIV = HAS_USER ? PRIV_USER : PRIV_MACHINE;

    mst_state_t state_r;
    mst_state_t state_nxt;
    logic [31:0] status_word;
    logic [31:0] merged;
    logic [31:0] view_mask;
    logic [4:0] legal_scheme;
    logic dirty_summary;
    logic cur_ie;

    function automatic logic priv_supported(input logic [1:0] p);
        logic ok;
        case (p)
            PRIV_MACHINE: ok = 1'b1;
            PRIV_HYPER: ok = HAS_HYPER;
            PRIV_SUPER: ok = HAS_SUPER;
            PRIV_USER: ok = HAS_USER;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : priv_supported

    function automatic logic [31:0] sel_mask(input mst_csr_sel_t sel);
        logic [31:0] m;
        case (sel)
            SEL_MACHINE_STATUS: m = VIEW_MASK_MACHINE;
            SEL_HYPER_STATUS: m = VIEW_MASK_HYPER;
            SEL_SUPER_STATUS: m = VIEW_MASK_SUPER;
            default: m = 32'h0000_0000;
        endcase
        return m;
    endfunction : sel_mask

    // Summary is derived, never stored, so it cannot go stale
    assign dirty_summary = (state_r.float_context_status == CTX_DIRTY) || (i_ext_status == CTX_DIRTY);

    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[POS_DIRTY_SUMMARY] = dirty_summary;
        status_word[POS_SCHEME_HI:POS_SCHEME_LO] = state_r.translation_scheme;
        status_word[POS_MAKE_EXEC_READABLE] = state_r.make_executable_readable;
        status_word[POS_PROTECT_USER_MEM] = state_r.protect_user_memory;
        status_word[POS_MODIFY_PRIV] = state_r.modify_privilege;
        status_word[POS_EXT_STATUS_LO+:2] = i_ext_status;
        status_word[POS_FLOAT_STATUS_LO+:2] = state_r.float_context_status;
        status_word[POS_MACHINE_PP_LO+:2] = state_r.machine_prior_privilege;
        status_word[POS_HYPER_PP_LO+:2] = state_r.hypervisor_prior_privilege;
        status_word[POS_SUPER_PP] = state_r.supervisor_prior_privilege;
        status_word[POS_PRIOR_IE_LO+:4] = state_r.prior_irq_enable;
        status_word[POS_IE_LO+:4] = state_r.irq_enable;
    end

    // Views share one storage; a narrower view only masks bits
    assign view_mask = sel_mask(i_csr_req.sel);
    assign merged = (status_word & ~view_mask) | (i_csr_req.wdata & view_mask);

    mst_scheme_legalizer #(
        .HAS_USER(HAS_USER),
        .HAS_SUPER(HAS_SUPER),
        .SCHEME_IMPL_MASK(SCHEME_IMPL_MASK)
    ) u_scheme (
        .i_req_scheme(merged[POS_SCHEME_HI:POS_SCHEME_LO]),
        .i_cur_scheme(state_r.translation_scheme),
        .o_scheme(legal_scheme)
    );

    mst_irq_gate u_gate (
        .i_cur_priv(state_r.priv),
        .i_irq_enable(state_r.irq_enable),
        .i_irq_pending(i_irq_pending),
        .o_irq_take(o_irq_take)
    );

    always_comb
    begin
        logic [1:0] x;
        logic [1:0] y;
        x = i_trap_req.mode;
        y = state_r.priv;
        state_nxt = state_r;
        state_nxt.rvalid = i_csr_req.rd;
        if (i_csr_req.rd)
        begin
            // Hart identifier reads any time, writes fall away
            if (i_csr_req.sel == SEL_HART_ID)
                state_nxt.rdata = HART_ID;
            else
                state_nxt.rdata = status_word & view_mask;
        end
        if (i_csr_req.wr && i_csr_req.sel != SEL_HART_ID)
        begin
            state_nxt.irq_enable = merged[POS_IE_LO+:4];
            state_nxt.prior_irq_enable = merged[POS_PRIOR_IE_LO+:4];
            // Illegal prior modes are dropped; machine only leaves this field at 11
            if (priv_supported(merged[POS_MACHINE_PP_LO+:2]))
                state_nxt.machine_prior_privilege = merged[POS_MACHINE_PP_LO+:2];
            if (HAS_HYPER && merged[POS_HYPER_PP_LO+:2] != PRIV_MACHINE
                && priv_supported(merged[POS_HYPER_PP_LO+:2]))
                state_nxt.hypervisor_prior_privilege = merged[POS_HYPER_PP_LO+:2];
            if (HAS_SUPER)
                state_nxt.supervisor_prior_privilege = merged[POS_SUPER_PP];
            state_nxt.translation_scheme = legal_scheme;
            if (HAS_FLOAT)
                state_nxt.float_context_status = merged[POS_FLOAT_STATUS_LO+:2];
            state_nxt.make_executable_readable = merged[POS_MAKE_EXEC_READABLE];
            state_nxt.protect_user_memory = merged[POS_PROTECT_USER_MEM];
            state_nxt.modify_privilege = merged[POS_MODIFY_PRIV];
        end
        // Trap outranks return, and both outrank a same-cycle register write
        if (i_trap_req.trap)
        begin
            state_nxt.prior_irq_enable[x] = state_r.irq_enable[y];
            state_nxt.irq_enable[x] = 1'b0;
            case (x)
                PRIV_MACHINE: state_nxt.machine_prior_privilege = y;
                PRIV_HYPER: state_nxt.hypervisor_prior_privilege = y;
                PRIV_SUPER: state_nxt.supervisor_prior_privilege = y[0];
                default: ;
            endcase
            state_nxt.priv = x;
        end
        else if (i_trap_req.trap_return)
        begin
            case (x)
                PRIV_MACHINE: y = state_r.machine_prior_privilege;
                PRIV_HYPER: y = state_r.hypervisor_prior_privilege;
                PRIV_SUPER: y = {1'b0, state_r.supervisor_prior_privilege};
                default: y = PRIV_USER;
            endcase
            state_nxt.irq_enable[y] = state_r.prior_irq_enable[x];
            state_nxt.priv = y;
            state_nxt.prior_irq_enable[x] = 1'b1;
            case (x)
                PRIV_MACHINE: state_nxt.machine_prior_privilege = LOWEST_PRIV;
                PRIV_HYPER: state_nxt.hypervisor_prior_privilege = LOWEST_PRIV;
                PRIV_SUPER: state_nxt.supervisor_prior_privilege = 1'b0;
                default: ;
            endcase
        end
        // Absent modes keep no storage
        state_nxt.irq_enable = state_nxt.irq_enable & IE_IMPL;
        state_nxt.prior_irq_enable = state_nxt.prior_irq_enable & IE_IMPL;
        if (!HAS_USER)
            state_nxt.machine_prior_privilege = PRIV_MACHINE;
        if (!HAS_HYPER)
            state_nxt.hypervisor_prior_privilege = PRIV_USER;
        if (!HAS_SUPER)
            state_nxt.supervisor_prior_privilege = 1'b0;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            state_r <= '0;
            state_r.priv <= RST_PRIV;
            state_r.irq_enable <= RST_IE;
            state_r.prior_irq_enable <= RST_PRIOR_IE;
            state_r.machine_prior_privilege <= RST_MACHINE_PP;
            state_r.translation_scheme <= RST_SCHEME;
            state_r.float_context_status <= RST_FLOAT_STATUS;
        end
        else
            state_r <= state_nxt;
    end

    assign o_csr_rdata = state_r.rdata;
    assign o_csr_rvalid = state_r.rvalid;
    assign o_cur_priv = state_r.priv;
    assign o_translation_scheme = state_r.translation_scheme;
    assign o_modify_privilege = state_r.modify_privilege;
    assign o_make_executable_readable = state_r.make_executable_readable;
    assign o_protect_user_memory = state_r.protect_user_memory;
    // Enable of the running mode, sampled by the stack checks
    assign cur_ie = state_r.irq_enable[state_r.priv];

    sequence s_trap_from(logic [1:0] md);
        i_trap_req.trap && i_trap_req.mode == md;
    endsequence

    sequence s_return_at(logic [1:0] md);
        !i_trap_req.trap && i_trap_req.trap_return && i_trap_req.mode == md;
    endsequence

    AST_HART_ID_READ: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_csr_req.rd && i_csr_req.sel == SEL_HART_ID |=> o_csr_rvalid && o_csr_rdata == HART_ID)
        else $error("hart identifier read returned wrong value");

    AST_HART_ZERO: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_csr_req.rd && i_csr_req.sel == SEL_HART_ID && HART_ID == 32'h0000_0000 |=> o_csr_rdata == 32'h0000_0000)
        else $error("hart zero did not read zero");

    AST_MACHINE_TRAP: assert property (@(posedge i_mclk) disable iff (i_rst)
        s_trap_from(PRIV_MACHINE) |=> o_cur_priv == PRIV_MACHINE && !state_r.irq_enable[3]
        && state_r.prior_irq_enable[3] == $past(cur_ie)
        && state_r.machine_prior_privilege == $past(state_r.priv))
        else $error("trap into machine mode stacked wrongly");

    AST_MACHINE_RETURN: assert property (@(posedge i_mclk) disable iff (i_rst)
        s_return_at(PRIV_MACHINE) |=> o_cur_priv == $past(state_r.machine_prior_privilege)
        && state_r.prior_irq_enable[3] && state_r.machine_prior_privilege == LOWEST_PRIV)
        else $error("machine return popped wrongly");

    AST_TRAP_RET_SEQ: assert property (@(posedge i_mclk) disable iff (i_rst)
        s_trap_from(PRIV_MACHINE) ##1 s_return_at(PRIV_MACHINE)
        |=> o_cur_priv == $past(o_cur_priv, 2) && cur_ie == $past(cur_ie, 2))
        else $error("trap then return did not restore state");

    AST_LOWER_MASKED: assert property (@(posedge i_mclk) disable iff (i_rst)
        (o_irq_take & ((4'h1 << o_cur_priv) - 4'h1)) == 4'h0)
        else $error("lower mode interrupt taken");

    AST_CURRENT_GATED: assert property (@(posedge i_mclk) disable iff (i_rst)
        o_irq_take[o_cur_priv] |-> state_r.irq_enable[o_cur_priv] && i_irq_pending[o_cur_priv])
        else $error("current mode interrupt taken while disabled");

    AST_SCHEME_LEGAL: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_csr_req.wr && i_csr_req.sel == SEL_MACHINE_STATUS && !i_trap_req.trap && !i_trap_req.trap_return
        && !SCHEME_IMPL_MASK[i_csr_req.wdata[POS_SCHEME_HI:POS_SCHEME_LO]]
        |=> $stable(o_translation_scheme))
        else $error("unsupported scheme was stored");

    AST_SCHEME_STORED_LEGAL: assert property (@(posedge i_mclk) disable iff (i_rst)
        SCHEME_IMPL_MASK[o_translation_scheme])
        else $error("stored scheme is not implemented");

    AST_RESET_BARE: assert property (@(posedge i_mclk)
        i_rst |=> o_translation_scheme == SCHEME_BARE && o_cur_priv == PRIV_MACHINE)
        else $error("reset did not select bare scheme");

    AST_DIRTY_SUMMARY: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_csr_req.rd && i_csr_req.sel == SEL_MACHINE_STATUS |=> o_csr_rdata[POS_DIRTY_SUMMARY]
        == (o_csr_rdata[POS_FLOAT_STATUS_LO+:2] == CTX_DIRTY || o_csr_rdata[POS_EXT_STATUS_LO+:2] == CTX_DIRTY))
        else $error("dirty summary mismatch");

    AST_USER_IRQ_ZERO: assert property (@(posedge i_mclk) disable iff (i_rst)
        !HAS_USER_IRQ |-> !state_r.irq_enable[0] && !state_r.prior_irq_enable[0])
        else $error("absent user interrupt enable set");

    AST_SUPER_VIEW: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_csr_req.rd && i_csr_req.sel == SEL_SUPER_STATUS |=> (o_csr_rdata & ~VIEW_MASK_SUPER) == 32'h0000_0000)
        else $error("supervisor view leaked machine bits");

endmodule : mst_status_core

// ### hdl/mst_pkg.sv
// Shared constants and carrier types for the machine status and trap stack block
package mst_pkg;

    localparam int XLEN = 32;

    // Privilege mode encodings
    localparam logic [1:0] PRIV_USER = 2'h0;
    localparam logic [1:0] PRIV_SUPER = 2'h1;
    localparam logic [1:0] PRIV_HYPER = 2'h2;
    localparam logic [1:0] PRIV_MACHINE = 2'h3;

    // Status field positions
    localparam int POS_DIRTY_SUMMARY = 31;
    localparam int POS_SCHEME_HI = 28;
    localparam int POS_SCHEME_LO = 24;
    localparam int POS_MAKE_EXEC_READABLE = 19;
    localparam int POS_PROTECT_USER_MEM = 18;
    localparam int POS_MODIFY_PRIV = 17;
    localparam int POS_EXT_STATUS_LO = 15;
    localparam int POS_FLOAT_STATUS_LO = 13;
    localparam int POS_MACHINE_PP_LO = 11;
    localparam int POS_HYPER_PP_LO = 9;
    localparam int POS_SUPER_PP = 8;
    localparam int POS_PRIOR_IE_LO = 4;
    localparam int POS_IE_LO = 0;

    // Restricted view masks onto the one status word
    localparam logic [31:0] VIEW_MASK_MACHINE = 32'hffff_ffff;
    localparam logic [31:0] VIEW_MASK_HYPER = 32'h8007_e777;
    localparam logic [31:0] VIEW_MASK_SUPER = 32'h8006_e133;

    // Translation scheme encodings
    localparam logic [4:0] SCHEME_BARE = 5'h00;
    localparam logic [4:0] SCHEME_BASE_BOUND = 5'h01;
    localparam logic [4:0] SCHEME_SPLIT_BASE_BOUND = 5'h02;
    localparam logic [4:0] SCHEME_PAGED_32 = 5'h08;
    localparam logic [4:0] SCHEME_PAGED_39 = 5'h09;
    localparam logic [4:0] SCHEME_PAGED_48 = 5'h0a;
    localparam logic [4:0] SCHEME_PAGED_57_RSVD = 5'h0b;
    localparam logic [4:0] SCHEME_PAGED_64_RSVD = 5'h0c;

    // Context status encodings
    localparam logic [1:0] CTX_OFF = 2'h0;
    localparam logic [1:0] CTX_INITIAL = 2'h1;
    localparam logic [1:0] CTX_CLEAN = 2'h2;
    localparam logic [1:0] CTX_DIRTY = 2'h3;

    // Reset values
    localparam logic [1:0] RST_PRIV = PRIV_MACHINE;
    localparam logic [3:0] RST_IE = 4'h0;
    localparam logic [3:0] RST_PRIOR_IE = 4'h0;
    localparam logic [1:0] RST_MACHINE_PP = PRIV_MACHINE;
    localparam logic [4:0] RST_SCHEME = SCHEME_BARE;
    localparam logic [1:0] RST_FLOAT_STATUS = CTX_OFF;

    typedef enum logic [1:0]
    {
        SEL_HART_ID = 2'b00,
        SEL_MACHINE_STATUS = 2'b01,
        SEL_HYPER_STATUS = 2'b10,
        SEL_SUPER_STATUS = 2'b11
    } mst_csr_sel_t;

    typedef struct packed
    {
        logic rd;
        logic wr;
        mst_csr_sel_t sel;
        logic [31:0] wdata;
    } mst_csr_req_t;

    typedef struct packed
    {
        logic trap;
        logic trap_return;
        logic [1:0] mode;
    } mst_trap_req_t;

endpackage : mst_pkg

// ### hdl/mst_scheme_legalizer.sv
// Translation scheme write legalizer
`timescale 1ns/1ps
module mst_scheme_legalizer
    import mst_pkg::*;
#(
    parameter bit HAS_USER = 1'b1,
    parameter bit HAS_SUPER = 1'b1,
    parameter logic [31:0] SCHEME_IMPL_MASK = 32'h0000_0107
)
(
    // Requested and current scheme
    input wire logic [4:0] i_req_scheme,
    input wire logic [4:0] i_cur_scheme,
    // Legal result
    output logic [4:0] o_scheme
);

    function automatic logic scheme_ok(input logic [4:0] s);
        logic ok;
        ok = SCHEME_IMPL_MASK[s];
        case (s)
            SCHEME_BARE: ok = 1'b1;
            SCHEME_BASE_BOUND, SCHEME_SPLIT_BASE_BOUND: ok = ok && HAS_USER;
            SCHEME_PAGED_32, SCHEME_PAGED_39, SCHEME_PAGED_48: ok = ok && HAS_USER && HAS_SUPER;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : scheme_ok

    // Unsupported request keeps the old legal value, so readback exposes support
    assign o_scheme = scheme_ok(i_req_scheme) ? i_req_scheme : i_cur_scheme;

endmodule : mst_scheme_legalizer

// ### hdl/mst_irq_gate.sv
// Per-mode interrupt gating against the current privilege
`timescale 1ns/1ps
module mst_irq_gate
    import mst_pkg::*;
(
    // Current state
    input wire logic [1:0] i_cur_priv,
    input wire logic [3:0] i_irq_enable,
    input wire logic [3:0] i_irq_pending,
    // Interrupts to take, one per target mode
    output logic [3:0] o_irq_take
);

    always_comb
    begin
        for (int m = 0; m < 4; m++)
        begin
            if (m > i_cur_priv)
                o_irq_take[m] = i_irq_pending[m];
            else if (m == i_cur_priv)
                o_irq_take[m] = i_irq_pending[m] & i_irq_enable[m];
            else
                o_irq_take[m] = 1'b0;
        end
    end

endmodule : mst_irq_gate

// ### tb/mst_trap_partner.sv
// Trap sequencing partner that pulses trap entry and return requests
`timescale 1ns/1ps
module mst_trap_partner
    import mst_pkg::*;
(
    // Clock
    input wire logic i_mclk,
    // Requests to the status block
    output mst_trap_req_t o_trap_req
);
    initial
    begin
        o_trap_req = '0;
    end

    // One-cycle pulse; gap idles first to model a slow pipeline
    task automatic pulse(input logic is_trap, input logic [1:0] mode, input int gap);
        repeat (gap + 1) @(posedge i_mclk);
        #1;
        o_trap_req.trap = is_trap;
        o_trap_req.trap_return = ~is_trap;
        o_trap_req.mode = mode;
        @(posedge i_mclk);
        #1;
        o_trap_req.trap = 1'b0;
        o_trap_req.trap_return = 1'b0;
        // Stale mode must not be relied on once the pulse is gone
        o_trap_req.mode = ~mode;
    endtask : pulse
endmodule : mst_trap_partner

// ### tb/tb.sv
// Self-checking bench for the machine status and trap stack block
`timescale 1ns/1ps
module tb;
    import mst_pkg::*;
    localparam logic [31:0] SCHEME_MASK = 32'h0000_0107;
    logic i_mclk;
    logic i_rst;
    mst_csr_req_t req;
    mst_trap_req_t trq;
    logic [1:0] ext;
    logic [3:0] pend;
    logic [31:0] rdata;
    logic rvalid;
    logic [3:0] take;
    logic [1:0] priv;
    logic [4:0] scheme;
    logic modify_priv;
    logic make_exec_rd;
    logic protect_user;
    int errors;
    int checks_done;
    logic [4:0] exp_scheme;

    mst_status_core #(.SCHEME_IMPL_MASK(SCHEME_MASK)) DUT (.i_mclk(i_mclk), .i_rst(i_rst), .i_csr_req(req),
        .o_csr_rdata(rdata), .o_csr_rvalid(rvalid), .i_trap_req(trq), .i_ext_status(ext),
        .i_irq_pending(pend), .o_irq_take(take), .o_cur_priv(priv), .o_translation_scheme(scheme),
        .o_modify_privilege(modify_priv), .o_make_executable_readable(make_exec_rd),
        .o_protect_user_memory(protect_user));

    mst_trap_partner u_partner (.i_mclk(i_mclk), .o_trap_req(trq));

    initial
    begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end

    task automatic report_and_stop();
        if (errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic csr_write(input mst_csr_sel_t sel, input logic [31:0] data);
        @(posedge i_mclk);
        #1;
        req.wr = 1'b1;
        req.sel = sel;
        req.wdata = data;
        @(posedge i_mclk);
        #1;
        req.wr = 1'b0;
        req.wdata = ~data;
    endtask : csr_write

    // Answer is due one cycle after the read edge; a few spare cycles bound the wait
    task automatic check_rd(input mst_csr_sel_t sel, input logic [31:0] exp);
        int n;
        @(posedge i_mclk);
        #1;
        req.rd = 1'b1;
        req.sel = sel;
        @(posedge i_mclk);
        #1;
        req.rd = 1'b0;
        n = 0;
        while (rvalid !== 1'b1 && n < 4)
        begin
            @(posedge i_mclk);
            #1;
            n++;
        end
        if (rvalid !== 1'b1)
        begin
            errors++;
            $display("ERROR %0t no read answer", $time);
            report_and_stop();
        end
        check(rdata, exp);
    endtask : check_rd

    task automatic check_port(input logic [1:0] exp_priv, input logic [3:0] exp_take);
        check({30'h0, priv}, {30'h0, exp_priv});
        check({28'h0, take}, {28'h0, exp_take});
    endtask : check_port

    initial
    begin
        errors = 0;
        checks_done = 0;
        i_rst = 1'b1;
        req = '0;
        ext = 2'h0;
        pend = 4'h0;
        repeat (20) @(posedge i_mclk);
        #1;
        i_rst = 1'b0;
        check_rd(SEL_MACHINE_STATUS, 32'h0000_1800);
        check_port(PRIV_MACHINE, 4'h0);
        check_rd(SEL_HART_ID, 32'h0);
        csr_write(SEL_HART_ID, 32'hffff_ffff);
        check_rd(SEL_HART_ID, 32'h0);
        ext = 2'h3;
        csr_write(SEL_MACHINE_STATUS, 32'hffff_ffff);
        check_rd(SEL_MACHINE_STATUS, 32'h800f_99aa);
        check({29'h0, make_exec_rd, protect_user, modify_priv}, 32'h7);
        check_rd(SEL_SUPER_STATUS, 32'h8006_8122);
        check_rd(SEL_HYPER_STATUS, 32'h8007_8122);
        csr_write(SEL_SUPER_STATUS, 32'h0);
        check_rd(SEL_MACHINE_STATUS, 32'h8009_9888);
        ext = 2'h2;
        check_rd(SEL_MACHINE_STATUS, 32'h0009_1888);
        ext = 2'h0;
        // Hypervisor code is not a supported mode here, so the field keeps machine
        csr_write(SEL_MACHINE_STATUS, 32'h0000_1000);
        check_rd(SEL_MACHINE_STATUS, 32'h0000_1800);
        exp_scheme = SCHEME_BARE;
        for (int v = 0; v < 32; v++)
        begin
            csr_write(SEL_MACHINE_STATUS, {3'h0, 5'(v), 24'h0});
            if (SCHEME_MASK[v])
                exp_scheme = 5'(v);
            check({27'h0, scheme}, {27'h0, exp_scheme});
        end
        check_rd(SEL_MACHINE_STATUS, 32'h0800_0000);
        i_rst = 1'b1;
        repeat (2) @(posedge i_mclk);
        #1;
        i_rst = 1'b0;
        check({27'h0, scheme}, {27'h0, SCHEME_BARE});
        pend = 4'hf;
        csr_write(SEL_MACHINE_STATUS, 32'h0000_0882);
        u_partner.pulse(1'b0, PRIV_MACHINE, 0);
        check_rd(SEL_MACHINE_STATUS, 32'h0000_0082);
        check_port(PRIV_SUPER, 4'he);
        u_partner.pulse(1'b1, PRIV_MACHINE, 2);
        check_rd(SEL_MACHINE_STATUS, 32'h0000_0882);
        check_port(PRIV_MACHINE, 4'h0);
        u_partner.pulse(1'b0, PRIV_MACHINE, 0);
        u_partner.pulse(1'b0, PRIV_SUPER, 0);
        check_rd(SEL_MACHINE_STATUS, 32'h0000_00a2);
        check_port(PRIV_USER, 4'he);
        u_partner.pulse(1'b1, PRIV_SUPER, 0);
        check_rd(SEL_MACHINE_STATUS, 32'h0000_0080);
        check_port(PRIV_SUPER, 4'hc);
        u_partner.pulse(1'b1, PRIV_MACHINE, 1);
        check_rd(SEL_MACHINE_STATUS, 32'h0000_0800);
        check_port(PRIV_MACHINE, 4'h0);
        csr_write(SEL_MACHINE_STATUS, 32'h0000_0808);
        check_port(PRIV_MACHINE, 4'h8);
        csr_write(SEL_HYPER_STATUS, 32'hffff_ffff);
        check_rd(SEL_MACHINE_STATUS, 32'h0006_092a);
        check({29'h0, make_exec_rd, protect_user, modify_priv}, 32'h3);
        u_partner.pulse(1'b0, PRIV_USER, 0);
        check_port(PRIV_USER, 4'he);
        report_and_stop();
    end
endmodule : tb
